// File: rtl/pursq_pkg.sv
package pursq_pkg;
  // 50 ms hold and its cycle count at 100 MHz
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned HOLD_MS       = 50;
  localparam int unsigned HOLD_CYCLES   = HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 23;
  // strap levels required on the legacy pins
  localparam logic CHIP_EN_B_LVL  = 1'b0;
  localparam logic RECFG_B_LVL    = 1'b1;
  localparam logic STATUS_B_LVL   = 1'b1;
  // power-up modes
  typedef enum logic {
    PURSQ_INSTANT,
    PURSQ_DELAYED
  } pursq_mode_t;
  // sequencer states
  typedef enum logic [1:0] {
    PURSQ_POR,
    PURSQ_HOLD,
    PURSQ_WAIT_PINS,
    PURSQ_RUN
  } pursq_state_t;
endpackage

// File: rtl/pursq_sync.sv
`timescale 1ns/100ps
module pursq_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// File: rtl/pursq_top.sv
`timescale 1ns/100ps
// How it works
// - power-on reset first clears every register except cfg_done_oe, which it sets
// - instant mode: pins good releases done to high-z
// - instant mode: usable right after reset, no configuration
// - delayed mode holds logic reset 50 ms
// - delayed mode drives done low during hold
// - no bitstream, emulation, upgrade or decryption
module pursq_top #(
  parameter pursq_pkg::pursq_mode_t MODE        = pursq_pkg::PURSQ_INSTANT,
  parameter int unsigned            HOLD_CYCLES = pursq_pkg::HOLD_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic chip_en_b_i,
  input  wire logic recfg_b_i,
  input  wire logic status_b_i,
  output logic      cfg_done_o,
  output logic      cfg_done_oe,
  output logic      core_rst_b_o,
  output logic      hold_active_o
);
  localparam int unsigned N_STRAP = 3;

  logic [N_STRAP-1:0]            strap_raw;
  logic [N_STRAP-1:0]            strap_s;
  logic                          chip_en_b_s;
  logic                          recfg_b_s;
  logic                          status_b_s;
  logic                          pins_ok;
  logic [pursq_pkg::CNT_W-1:0]   cnt_q;
  logic                          cnt_done;
  logic [pursq_pkg::CNT_W-1:0]   hold_len_q;
  pursq_pkg::pursq_state_t       state_q;

  // strap pins come from the board, gathered for the synchronisers
  assign strap_raw = {status_b_i, recfg_b_i, chip_en_b_i};

  // one two-flop synchroniser per strap, no logic reads the raw pins
  generate
    for (genvar g = 0; g < N_STRAP; g++) begin : g_sync
      pursq_sync u_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (strap_raw[g]),
        .dout  (strap_s[g])
      );
    end
  endgenerate

  // synchronised straps back into their roles
  assign {status_b_s, recfg_b_s, chip_en_b_s} = strap_s;

  // device relies on the board holding these levels
  assign pins_ok = (chip_en_b_s == pursq_pkg::CHIP_EN_B_LVL)
                && (recfg_b_s == pursq_pkg::RECFG_B_LVL)
                && (status_b_s == pursq_pkg::STATUS_B_LVL);

  assign cnt_done = (cnt_q == pursq_pkg::CNT_W'(HOLD_CYCLES - 1));

  // hold timer, counts only in the hold state until it expires
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (state_q == pursq_pkg::PURSQ_HOLD && !cnt_done) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // sequencer; mode is a build parameter, no configuration path exists
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q <= pursq_pkg::PURSQ_POR;
    end else begin
      unique case (state_q)
        pursq_pkg::PURSQ_POR: begin
          if (MODE == pursq_pkg::PURSQ_DELAYED) begin
            state_q <= pursq_pkg::PURSQ_HOLD;
          end else begin
            state_q <= pursq_pkg::PURSQ_WAIT_PINS;
          end
        end
        pursq_pkg::PURSQ_HOLD: begin
          if (cnt_done) begin
            state_q <= pursq_pkg::PURSQ_WAIT_PINS;
          end
        end
        pursq_pkg::PURSQ_WAIT_PINS: begin
          if (pins_ok) begin
            state_q <= pursq_pkg::PURSQ_RUN;
          end
        end
        pursq_pkg::PURSQ_RUN: begin
          state_q <= pursq_pkg::PURSQ_RUN;
        end
      endcase
    end
  end

  // outputs: done pin driven low until released, core held in reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfg_done_oe   <= 1'b1;
      core_rst_b_o  <= 1'b0;
      hold_active_o <= 1'b0;
    end else begin
      cfg_done_oe   <= !(state_q == pursq_pkg::PURSQ_WAIT_PINS && pins_ok)
                       && (state_q != pursq_pkg::PURSQ_RUN);
      core_rst_b_o  <= (state_q == pursq_pkg::PURSQ_WAIT_PINS && pins_ok)
                       || (state_q == pursq_pkg::PURSQ_RUN);
      hold_active_o <= (state_q == pursq_pkg::PURSQ_HOLD && !cnt_done)
                       || (state_q == pursq_pkg::PURSQ_POR
                           && MODE == pursq_pkg::PURSQ_DELAYED);
    end
  end

  assign cfg_done_o = 1'b0; // only ever pulls low

  // cycles the hold flag has stood since reset, read only by the checks
  // stops at the hold length, so the timer width is enough
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      hold_len_q <= '0;
    end else if (hold_active_o) begin
      hold_len_q <= hold_len_q + 1'b1;
    end
  end

  // checks watch the enable, not the pin value: the done pin only pulls low
  // and its high level comes from the board pull-up
  // strap loss after release is ignored on purpose, nothing can reconfigure
  // the core, so no check expects a return to the wait state

  // delayed mode, hold in progress
  sequence hold_seq;
    state_q == pursq_pkg::PURSQ_HOLD;
  endsequence

  // hold still counting toward its end
  sequence hold_run_seq;
    state_q == pursq_pkg::PURSQ_HOLD && !cnt_done;
  endsequence

  // waiting with good straps, release due next edge
  sequence release_seq;
    state_q == pursq_pkg::PURSQ_WAIT_PINS && pins_ok;
  endsequence

  // waiting with wrong straps, release refused
  sequence refuse_seq;
    state_q == pursq_pkg::PURSQ_WAIT_PINS && !pins_ok;
  endsequence

  // first edge out of power-on reset
  sequence por_exit_seq;
    state_q == pursq_pkg::PURSQ_POR;
  endsequence

  // hold keeps done driven low and the core in reset
  hold_drives_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hold_seq |=> cfg_done_oe)
    else $error("done pin not driven low during hold");

  hold_reset_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hold_seq |=> !core_rst_b_o)
    else $error("core released during hold");

  // hold flag stands for every counting cycle
  hold_flag_a: assert property (@(posedge mclk) disable iff (!rst_b)
    hold_run_seq |=> hold_active_o)
    else $error("hold flag low while counting");

  // flag stands exactly the hold length once the hold ends
  hold_len_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(hold_active_o) && state_q == pursq_pkg::PURSQ_WAIT_PINS
      |-> hold_len_q == pursq_pkg::CNT_W'(HOLD_CYCLES))
    else $error("hold flag length wrong");

  // good straps release, wrong straps refuse
  release_pins_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_q == pursq_pkg::PURSQ_WAIT_PINS && pins_ok) |=> !cfg_done_oe && core_rst_b_o)
    else $error("release missing after pins good");

  refuse_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
    refuse_seq |=> cfg_done_oe && !core_rst_b_o
                   && state_q == pursq_pkg::PURSQ_WAIT_PINS)
    else $error("released on wrong straps");

  // released state is final until reset
  run_stays_a: assert property (@(posedge mclk) disable iff (!rst_b)
    state_q == pursq_pkg::PURSQ_RUN |=> state_q == pursq_pkg::PURSQ_RUN)
    else $error("left run state");

  // instant mode never holds
  instant_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (MODE == pursq_pkg::PURSQ_INSTANT) |-> state_q != pursq_pkg::PURSQ_HOLD)
    else $error("instant mode entered hold");

  flag_quiet_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (MODE == pursq_pkg::PURSQ_INSTANT) |-> !hold_active_o)
    else $error("hold flag raised in instant mode");

  // power-on reset exit picks the path by mode
  por_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    por_exit_seq |=> state_q == ((MODE == pursq_pkg::PURSQ_DELAYED)
                                 ? pursq_pkg::PURSQ_HOLD : pursq_pkg::PURSQ_WAIT_PINS))
    else $error("wrong state after power-on reset");

  // hold timer steps only while counting
  timer_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (hold_seq and !cnt_done) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("hold timer did not advance");

  timer_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !(state_q == pursq_pkg::PURSQ_HOLD && !cnt_done) |=> $stable(cnt_q))
    else $error("hold timer moved outside hold");

  hold_end_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (hold_seq and cnt_done) |=> state_q == pursq_pkg::PURSQ_WAIT_PINS)
    else $error("hold did not end at count");

  // reset clears state, timer, hold flag and core reset, and sets the done enable
  por_clear_a: assert property (@(posedge mclk)
    !rst_b |=> state_q == pursq_pkg::PURSQ_POR && cnt_q == '0)
    else $error("reset did not clear state");

  reset_outs_a: assert property (@(posedge mclk)
    !rst_b |=> cfg_done_oe && !core_rst_b_o && !hold_active_o)
    else $error("reset did not clear outputs");
endmodule

// File: verification/pursq_board.sv
`timescale 1ns/100ps
// board straps on the legacy pins, inverted on request
module pursq_board (
  input  wire logic bad,
  output logic      chip_en_b,
  output logic      recfg_b,
  output logic      status_b
);
  // required levels, all flipped when bad is set
  assign chip_en_b = pursq_pkg::CHIP_EN_B_LVL ^ bad;
  assign recfg_b   = pursq_pkg::RECFG_B_LVL ^ bad;
  assign status_b  = pursq_pkg::STATUS_B_LVL ^ bad;
endmodule

// File: verification/tb_pursq_top.sv
`timescale 1ns/100ps
module tb_pursq_top;
  localparam int unsigned HOLD = 20;
  logic       mclk = 1'b0;
  logic       rst_b = 1'b0;
  logic       bad = 1'b0;
  logic       ce_b;
  logic       rc_b;
  logic       st_b;
  logic [1:0] done;
  logic [1:0] oe;
  logic [1:0] crst_b;
  logic [1:0] hold;
  int         n_mismatch = 0;
  int         n_checks = 0;
  int         ti;
  int         td;
  int         h;
  // clock, 100 MHz
  always #5 mclk = ~mclk;
  pursq_board i_pursq_board (.bad(bad), .chip_en_b(ce_b), .recfg_b(rc_b), .status_b(st_b));
  // bit 0 instant mode, bit 1 delayed mode
  pursq_top #(.MODE(pursq_pkg::PURSQ_INSTANT), .HOLD_CYCLES(HOLD)) i_pursq_top (
    .mclk(mclk), .rst_b(rst_b), .chip_en_b_i(ce_b), .recfg_b_i(rc_b), .status_b_i(st_b),
    .cfg_done_o(done[0]), .cfg_done_oe(oe[0]), .core_rst_b_o(crst_b[0]),
    .hold_active_o(hold[0]));
  pursq_top #(.MODE(pursq_pkg::PURSQ_DELAYED), .HOLD_CYCLES(HOLD)) i_pursq_top_dly (
    .mclk(mclk), .rst_b(rst_b), .chip_en_b_i(ce_b), .recfg_b_i(rc_b), .status_b_i(st_b),
    .cfg_done_o(done[1]), .cfg_done_oe(oe[1]), .core_rst_b_o(crst_b[1]),
    .hold_active_o(hold[1]));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  // reset both, then count held cycles and hold cycles over 100 edges
  task automatic power_up();
    ti = 0;
    td = 0;
    h = 0;
    rst_b = 1'b0;
    step();
    step();
    check(oe, 2'b11, "done not driven in reset");
    check(crst_b, 2'b00, "core not reset");
    rst_b = 1'b1;
    for (int n = 0; n < 100; n++) begin
      step();
      ti += (crst_b[0] !== 1'b1);
      td += (crst_b[1] !== 1'b1);
      h += (hold[1] === 1'b1);
      check(oe, 2'(~crst_b), "done enable vs core reset");
      check({done, hold[0]}, 3'h0, "done level or instant hold");
    end
  endtask
  // good straps: instant release, delayed release after the hold
  task automatic good_seq();
    bad = 1'b0;
    power_up();
    check(ti <= 5, 1'b1, "instant release late");
    check(td, HOLD + 1, "hold length");
    check(h, HOLD, "hold flag length");
    check({oe, crst_b}, 4'h3, "not released");
  endtask
  // bad straps refuse release, fixing them releases, later loss ignored
  task automatic bad_straps();
    bad = 1'b1;
    power_up();
    check({oe, crst_b}, 4'hC, "released on bad straps");
    bad = 1'b0;
    for (int n = 0; n < 10 && crst_b !== 2'b11; n++) step();
    check(crst_b, 2'b11, "no release after straps fixed");
    if (crst_b !== 2'b11) test_done();
    bad = 1'b1;
    repeat (5) step();
    check({oe, crst_b}, 4'h3, "strap loss acted on");
  endtask
  initial begin
    good_seq();
    bad_straps();
    test_done();
  end
endmodule
